//--- irq_prio_pkg.sv
package irq_prio_pkg;

    // bus geometry
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int REG_W      = 16;
    localparam int BYTE_SHIFT = 2;   // byte address = index * 4

    // register indices as printed; byte address is index << BYTE_SHIFT
    localparam logic [3:0] IDX_PRIORITY_CFG_7   = 4'h7;
    localparam logic [3:0] IDX_PRIORITY_CFG_8   = 4'h8;
    localparam logic [3:0] IDX_PRIORITY_CFG_9   = 4'h9;
    localparam logic [3:0] IDX_VECTOR_BASE      = 4'ha;
    localparam logic [3:0] IDX_FAST_IRQ0_SELECT = 4'hb;

    // writable bits; everything else is reserved, reads zero, ignores writes
    localparam logic [15:0] MASK_PRIORITY_CFG_7   = 16'hffff;
    localparam logic [15:0] MASK_PRIORITY_CFG_8   = 16'hf3ff;
    localparam logic [15:0] MASK_PRIORITY_CFG_9   = 16'hffff;
    localparam logic [15:0] MASK_VECTOR_BASE      = 16'h1fff;
    localparam logic [15:0] MASK_FAST_IRQ0_SELECT = 16'h007f;

    // reset values
    localparam logic [15:0] RESET_REG = 16'h0000;

    // priority field layout and codes
    localparam int FIELD_W        = 2;
    localparam int FIELDS_PER_REG = 8;
    localparam int NUM_PRIO_REGS  = 3;
    localparam int NUM_SOURCES    = FIELDS_PER_REG * NUM_PRIO_REGS;
    localparam logic [1:0] PRIO_DISABLED = 2'h0;
    localparam logic [1:0] PRIO_LEVEL_0  = 2'h1;
    localparam logic [1:0] PRIO_LEVEL_1  = 2'h2;
    localparam logic [1:0] PRIO_LEVEL_2  = 2'h3;

    // vector address bus composition
    localparam int VAB_W      = 21;
    localparam int VBASE_W    = 13;
    localparam int VLOW_W     = 8;
    localparam int FAST_NUM_W = 7;

    // vector number of source 0; arbitrary default, real map lies elsewhere
    localparam logic [7:0] VEC_FIRST_DEFAULT = 8'h10;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- irq_prio_select.sv
`timescale 1ns/1ps

module irq_prio_select #(
    parameter int         N         = irq_prio_pkg::NUM_SOURCES,
    parameter logic [7:0] VEC_FIRST = irq_prio_pkg::VEC_FIRST_DEFAULT
) (
    input  wire logic [N-1:0]   req,
    input  wire logic [2*N-1:0] prio,
    input  wire logic [6:0]     fastNum,
    output logic                found,
    output logic [1:0]          code,
    output logic [7:0]          vecNum,
    output logic                fastHit
);

    // rank: fast boost above plain level 2, then the level code
    function automatic logic [2:0] rankOf(input logic [1:0] c, input logic f);
        rankOf = {f && (c == irq_prio_pkg::PRIO_LEVEL_2), c};
    endfunction

    // linear scan; strict compare keeps the lowest index on a tie
    always_comb begin
        logic [2:0] bestRank;
        logic [1:0] c;
        logic [7:0] v;
        logic       f;
        bestRank = 3'h0;
        c        = 2'h0;
        v        = 8'h00;
        f        = 1'b0;
        found    = 1'b0;
        code     = irq_prio_pkg::PRIO_DISABLED;
        vecNum   = 8'h00;
        fastHit  = 1'b0;
        for (int i = 0; i < N; i++) begin
            c = prio[2*i +: 2];
            v = VEC_FIRST + 8'(i);
            f = (v[6:0] == fastNum);
            // code 00 never competes, so disabled sources are never sent on
            if (req[i] && c != irq_prio_pkg::PRIO_DISABLED
                    && rankOf(c, f) > bestRank) begin
                bestRank = rankOf(c, f);
                found    = 1'b1;
                code     = c;
                vecNum   = v;
                fastHit  = bestRank[2];
            end
        end
    end

endmodule // irq_prio_select

//--- irq_priority_vector_base.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps


module irq_priority_vector_base #(
    parameter logic [7:0] VEC_FIRST = irq_prio_pkg::VEC_FIRST_DEFAULT
) (
    input  wire logic                                 sys_clk,
    input  wire logic                                 reset,
    // AXI4-Lite slave
    input  wire logic [irq_prio_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                                 s_axi_awvalid,
    output logic                                      s_axi_awready,
    input  wire logic [irq_prio_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                           s_axi_wstrb,
    input  wire logic                                 s_axi_wvalid,
    output logic                                      s_axi_wready,
    output logic [1:0]                                s_axi_bresp,
    output logic                                      s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    input  wire logic [irq_prio_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                                 s_axi_arvalid,
    output logic                                      s_axi_arready,
    output logic [irq_prio_pkg::AXI_DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                                s_axi_rresp,
    output logic                                      s_axi_rvalid,
    input  wire logic                                 s_axi_rready,
    // request lines from peripherals on this clock
    input  wire logic [irq_prio_pkg::NUM_SOURCES-1:0] irqReq,
    // fast interrupt 0 target, held outside this block
    input  wire logic [irq_prio_pkg::VAB_W-1:0]       fastVecAddr0,
    // towards the core
    output logic                                      irqValid,
    output logic [1:0]                                irqLevel,
    output logic                                      fastIrqHit,
    output logic [irq_prio_pkg::VAB_W-1:0]            vectorAddrBus
);

    // register storage
    logic [15:0] prioCfg7_q;
    logic [15:0] prioCfg8_q;
    logic [15:0] prioCfg9_q;
    logic [15:0] vectorBase_q;
    logic [15:0] fastSel_q;

    // write channel state
    logic                                awHeld_q;
    logic                                awHeld_d;
    logic [irq_prio_pkg::AXI_ADDR_W-1:0] awAddr_q;
    logic                                wHeld_q;
    logic                                wHeld_d;
    logic [15:0]                         wData_q;
    logic [1:0]                          wStrb_q;
    logic                                awReady_q;
    logic                                wReady_q;
    logic                                bValid_q;
    logic                                bValid_d;
    logic [1:0]                          bResp_q;

    // read channel state
    logic                                arReady_q;
    logic                                rValid_q;
    logic                                rValid_d;
    logic [irq_prio_pkg::AXI_DATA_W-1:0] rData_q;
    logic [1:0]                          rResp_q;

    // handshakes and decode
    logic        awFire;
    logic        wFire;
    logic        arFire;
    logic        doWrite;
    logic        wrHit;
    logic        rdHit;
    logic [3:0]  wrIdx;
    logic [3:0]  rdIdx;
    logic [15:0] rdWord;

    // arbitration result
    logic                             selFound;
    logic [1:0]                       selCode;
    logic [7:0]                       selVec;
    logic                             selFast;
    logic [2*irq_prio_pkg::NUM_SOURCES-1:0] prioFlat;

    // word index of a byte address; misaligned low bits are ignored
    function automatic logic [3:0] regIndex(
        input logic [irq_prio_pkg::AXI_ADDR_W-1:0] addr);
        regIndex = addr[irq_prio_pkg::BYTE_SHIFT +: 4];
    endfunction

    // true when an address lands on an implemented register
    function automatic logic regMapped(
        input logic [irq_prio_pkg::AXI_ADDR_W-1:0] addr);
        logic [3:0] idx;
        idx = addr[irq_prio_pkg::BYTE_SHIFT +: 4];
        regMapped = (addr[irq_prio_pkg::AXI_ADDR_W-1:irq_prio_pkg::BYTE_SHIFT+4] == '0)
                 && idx >= irq_prio_pkg::IDX_PRIORITY_CFG_7
                 && idx <= irq_prio_pkg::IDX_FAST_IRQ0_SELECT;
    endfunction

    // merge write data through byte strobes and the writable mask
    function automatic logic [15:0] mergeWrite(
        input logic [15:0] old,
        input logic [15:0] wd,
        input logic [1:0]  strb,
        input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        mergeWrite = (old & ~lanes) | (wd & lanes);
    endfunction

    // channel handshakes
    assign awFire  = s_axi_awvalid && awReady_q;
    assign wFire   = s_axi_wvalid && wReady_q;
    assign arFire  = s_axi_arvalid && arReady_q;
    // commit one cycle after both halves are held, never while a response waits
    assign doWrite = awHeld_q && wHeld_q && !bValid_q;
    assign wrIdx   = regIndex(awAddr_q);
    assign wrHit   = regMapped(awAddr_q);
    assign rdIdx   = regIndex(s_axi_araddr);
    assign rdHit   = regMapped(s_axi_araddr);

    // next state of the write bookkeeping
    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d  = wHeld_q;
        bValid_d = bValid_q;
        if (awFire) begin
            awHeld_d = 1'b1;
        end
        if (wFire) begin
            wHeld_d = 1'b1;
        end
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d  = 1'b0;
            bValid_d = 1'b1;
        end else if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end
    end

    // address and data may arrive in either order; each is held until used
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            awHeld_q  <= 1'b0;
            wHeld_q   <= 1'b0;
            awAddr_q  <= '0;
            wData_q   <= 16'h0000;
            wStrb_q   <= 2'h0;
            awReady_q <= 1'b0;
            wReady_q  <= 1'b0;
            bValid_q  <= 1'b0;
            bResp_q   <= irq_prio_pkg::RESP_OKAY;
        end else begin
            awHeld_q  <= awHeld_d;
            wHeld_q   <= wHeld_d;
            bValid_q  <= bValid_d;
            // ready drops once a half is held, so no second beat overwrites it
            awReady_q <= !awHeld_d && !bValid_d;
            wReady_q  <= !wHeld_d && !bValid_d;
            if (awFire) begin
                awAddr_q <= s_axi_awaddr;
            end
            if (wFire) begin
                wData_q <= s_axi_wdata[15:0];
                wStrb_q <= s_axi_wstrb[1:0];
            end
            if (doWrite) begin
                bResp_q <= wrHit ? irq_prio_pkg::RESP_OKAY : irq_prio_pkg::RESP_SLVERR;
            end
        end
    end

    // priority registers; upper data lanes hold nothing and are dropped
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prioCfg7_q <= irq_prio_pkg::RESET_REG;
            prioCfg8_q <= irq_prio_pkg::RESET_REG;
            prioCfg9_q <= irq_prio_pkg::RESET_REG;
        end else if (doWrite && wrHit) begin
            if (wrIdx == irq_prio_pkg::IDX_PRIORITY_CFG_7) begin
                prioCfg7_q <= mergeWrite(prioCfg7_q, wData_q, wStrb_q,
                                         irq_prio_pkg::MASK_PRIORITY_CFG_7);
            end
            if (wrIdx == irq_prio_pkg::IDX_PRIORITY_CFG_8) begin
                prioCfg8_q <= mergeWrite(prioCfg8_q, wData_q, wStrb_q,
                                         irq_prio_pkg::MASK_PRIORITY_CFG_8);
            end
            if (wrIdx == irq_prio_pkg::IDX_PRIORITY_CFG_9) begin
                prioCfg9_q <= mergeWrite(prioCfg9_q, wData_q, wStrb_q,
                                         irq_prio_pkg::MASK_PRIORITY_CFG_9);
            end
        end
    end

    // vector base and fast select; reserved bits never reach the flops
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            vectorBase_q <= irq_prio_pkg::RESET_REG;
            fastSel_q    <= irq_prio_pkg::RESET_REG;
        end else if (doWrite && wrHit) begin
            if (wrIdx == irq_prio_pkg::IDX_VECTOR_BASE) begin
                vectorBase_q <= mergeWrite(vectorBase_q, wData_q, wStrb_q,
                                           irq_prio_pkg::MASK_VECTOR_BASE);
            end
            if (wrIdx == irq_prio_pkg::IDX_FAST_IRQ0_SELECT) begin
                fastSel_q <= mergeWrite(fastSel_q, wData_q, wStrb_q,
                                        irq_prio_pkg::MASK_FAST_IRQ0_SELECT);
            end
        end
    end

    // read mux; masks again so a reserved bit can never leak out
    always_comb begin
        rdWord = 16'h0000;
        case (rdIdx)
            irq_prio_pkg::IDX_PRIORITY_CFG_7: begin
                rdWord = prioCfg7_q & irq_prio_pkg::MASK_PRIORITY_CFG_7;
            end
            irq_prio_pkg::IDX_PRIORITY_CFG_8: begin
                rdWord = prioCfg8_q & irq_prio_pkg::MASK_PRIORITY_CFG_8;
            end
            irq_prio_pkg::IDX_PRIORITY_CFG_9: begin
                rdWord = prioCfg9_q & irq_prio_pkg::MASK_PRIORITY_CFG_9;
            end
            irq_prio_pkg::IDX_VECTOR_BASE: begin
                rdWord = vectorBase_q & irq_prio_pkg::MASK_VECTOR_BASE;
            end
            irq_prio_pkg::IDX_FAST_IRQ0_SELECT: begin
                rdWord = fastSel_q & irq_prio_pkg::MASK_FAST_IRQ0_SELECT;
            end
            default: begin
                rdWord = 16'h0000;
            end
        endcase
        if (!rdHit) begin
            rdWord = 16'h0000;
        end
    end

    // read response holds until rready
    always_comb begin
        rValid_d = rValid_q;
        if (arFire) begin
            rValid_d = 1'b1;
        end else if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
        end
    end

    // one read in flight; data latched with the address, no read side effects
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            arReady_q <= 1'b0;
            rValid_q  <= 1'b0;
            rData_q   <= '0;
            rResp_q   <= irq_prio_pkg::RESP_OKAY;
        end else begin
            rValid_q  <= rValid_d;
            arReady_q <= !rValid_d;
            if (arFire) begin
                rData_q <= {16'h0000, rdWord};
                rResp_q <= rdHit ? irq_prio_pkg::RESP_OKAY : irq_prio_pkg::RESP_SLVERR;
            end
        end
    end

    // source i sits in field i mod 8 of register 7 + i div 8
    assign prioFlat = {prioCfg9_q, prioCfg8_q, prioCfg7_q};

    // priority arbitration over all sources
    irq_prio_select #(
        .N         (irq_prio_pkg::NUM_SOURCES),
        .VEC_FIRST (VEC_FIRST)
    ) u_select (
        .req     (irqReq),
        .prio    (prioFlat),
        .fastNum (fastSel_q[irq_prio_pkg::FAST_NUM_W-1:0]),
        .found   (selFound),
        .code    (selCode),
        .vecNum  (selVec),
        .fastHit (selFast)
    );

    // core side outputs; one cycle behind the requests to keep the path short
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irqValid      <= 1'b0;
            irqLevel      <= 2'h0;
            fastIrqHit    <= 1'b0;
            vectorAddrBus <= '0;
        end else begin
            irqValid   <= selFound;
            // level number is the code less one; forced to 0 while irqValid is low
            irqLevel   <= selFound ? selCode - 2'h1 : 2'h0;
            fastIrqHit <= selFound && selFast;
            if (selFound && selFast) begin
                vectorAddrBus <= fastVecAddr0;
            end else begin
                vectorAddrBus <= {vectorBase_q[irq_prio_pkg::VBASE_W-1:0],
                                  selVec};
            end
        end
    end

    // bus outputs straight from flops
    assign s_axi_awready = awReady_q;
    assign s_axi_wready  = wReady_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;

endmodule // irq_priority_vector_base

//--- irq_priority_vector_base_monitor.sv
`timescale 1ns/1ps

module irq_priority_vector_base_monitor (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [23:0] irqReq,
    input wire logic [20:0] fastVecAddr0,
    input wire logic        irqValid,
    input wire logic [1:0]  irqLevel,
    input wire logic        fastIrqHit,
    input wire logic [20:0] vectorAddrBus
);
    // one clock domain, so clocking and disable are stated once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // write is taken on both channels at one edge, answer lands two cycles later
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence respLate;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    chk_reset_quiet: assert property ($fell(reset) |-> !irqValid && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active right after reset");
    chk_write_resp: assert property (wrTaken |=> respLate)
        else $error("write response not on time");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_arready)
        else $error("upper read bits set or address taken during read");
    chk_no_request: assert property (irqReq == 24'h000000 |=> !irqValid)
        else $error("request forwarded with no source active");
    chk_level_range: assert property (irqValid |-> irqLevel != 2'h3)
        else $error("level beyond two");
    chk_idle_vector: assert property (!irqValid |-> irqLevel == 2'h0 && vectorAddrBus[7:0] == 8'h00 && !fastIrqHit)
        else $error("idle outputs not cleared");
    chk_fast_addr: assert property (fastIrqHit |-> irqValid && irqLevel == 2'h2 && vectorAddrBus == $past(fastVecAddr0))
        else $error("fast vector address wrong");
endmodule // irq_priority_vector_base_monitor

bind irq_priority_vector_base irq_priority_vector_base_monitor i_irq_priority_vector_base_monitor (
    .sys_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irqReq, .fastVecAddr0, .irqValid,
    .irqLevel, .fastIrqHit, .vectorAddrBus
);

//--- irq_core_model.sv
`timescale 1ns/1ps

module irq_core_model #(
    parameter logic [20:0] FAST_ADDR = 21'h1f2345   // arbitrary routine address
) (
    input  wire logic        sys_clk,
    input  wire logic        irqValid,
    input  wire logic [1:0]  irqLevel,
    input  wire logic        fastIrqHit,
    input  wire logic [20:0] vectorAddrBus,
    output logic [20:0]      fastVecAddr0,
    output logic [20:0]      fetchAddr,
    output logic [1:0]       fetchLevel,
    output logic             fetchFast
);
    // fast routine address stays put, like the fast address registers it stands for
    assign fastVecAddr0 = FAST_ADDR;

    // core fetches whatever vector is offered; no acknowledge, level requests only
    always_ff @(posedge sys_clk) begin
        if (irqValid) begin
            fetchAddr  <= vectorAddrBus;
            fetchLevel <= irqLevel;
            fetchFast  <= fastIrqHit;
        end
    end
endmodule // irq_core_model

//--- test_irq_priority_vector_base.sv
`timescale 1ns/1ps

module test_irq_priority_vector_base;
    localparam logic [20:0] FAST_ADDR = 21'h1f2345;
    localparam logic [7:0]  VF        = irq_prio_pkg::VEC_FIRST_DEFAULT;
    localparam int          TIMEOUT   = 20000;

    logic        sys_clk, reset;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, irqLevel, fetchLevel;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, irqValid, fastIrqHit, fetchFast;
    logic [23:0] irqReq;
    logic [20:0] fastVecAddr0, vectorAddrBus, fetchAddr;
    int          numErrors, totalChecks, cycleCount;

    irq_priority_vector_base i_irq_priority_vector_base (
        .sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irqReq, .fastVecAddr0, .irqValid,
        .irqLevel, .fastIrqHit, .vectorAddrBus);
    irq_core_model #(.FAST_ADDR(FAST_ADDR)) i_irq_core_model (
        .sys_clk, .irqValid, .irqLevel, .fastIrqHit, .vectorAddrBus, .fastVecAddr0,
        .fetchAddr, .fetchLevel, .fetchFast);

    // 50 MHz
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] addrOf(input int idx);
        return 8'(idx * 4);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        totalChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    // both channels offered together, each dropped at its own handshake
    task automatic axi_write(input logic [7:0] a, input logic [15:0] d, input logic [3:0] st,
                             output logic [1:0] r);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone  = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {16'h0000, d};
        s_axi_wstrb   <= st;
        s_axi_wvalid  <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge sys_clk);
            if (!awDone && s_axi_awready === 1'b1) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready === 1'b1) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // requests are sampled at one edge, outputs show after the next
    task automatic settle();
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic test_reset_values();
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 7; k <= 11; k++) begin
            axi_read(addrOf(k), d, r);
            check(d, 32'h0, "reset value");
        end
        check(irqValid, 1'b0, "idle request");
    endtask

    task automatic test_reserved();
        logic [15:0] masks [5];
        logic [31:0] d;
        logic [1:0]  r;
        masks = '{irq_prio_pkg::MASK_PRIORITY_CFG_7, irq_prio_pkg::MASK_PRIORITY_CFG_8,
                  irq_prio_pkg::MASK_PRIORITY_CFG_9, irq_prio_pkg::MASK_VECTOR_BASE,
                  irq_prio_pkg::MASK_FAST_IRQ0_SELECT};
        for (int k = 0; k < 5; k++) begin
            axi_write(addrOf(7 + k), 16'hffff, 4'hf, r);
            check(r, irq_prio_pkg::RESP_OKAY, "write resp");
            axi_read(addrOf(7 + k), d, r);
            check(d, {16'h0000, masks[k]}, "reserved bits");
        end
        // only the low lane enabled: upper byte must survive
        axi_write(addrOf(9), 16'h0000, 4'h1, r);
        axi_read(addrOf(9), d, r);
        check(d, 32'h0000ff00, "byte lane");
        axi_write(8'h30, 16'hffff, 4'hf, r);
        check(r, irq_prio_pkg::RESP_SLVERR, "unmapped write");
        axi_read(8'h30, d, r);
        check({d[29:0], r}, 32'h0 | irq_prio_pkg::RESP_SLVERR, "unmapped read");
    endtask

    // every source, every code, alone; source 13 sits on reserved bits
    task automatic test_fields();
        logic [1:0] r;
        logic       exp;
        axi_write(addrOf(10), 16'h1a5b, 4'h3, r);
        axi_write(addrOf(11), 16'h0000, 4'h3, r);
        for (int k = 7; k <= 9; k++) axi_write(addrOf(k), 16'h0000, 4'h3, r);
        for (int i = 0; i < 24; i++) begin
            for (int c = 0; c < 4; c++) begin
                axi_write(addrOf(7 + i / 8), 16'(c) << (2 * (i % 8)), 4'h3, r);
                irqReq <= 24'h1 << i;
                settle();
                exp = (c != 0) && (i != 13);
                check(irqValid, exp, "valid");
                check(irqLevel, exp ? 2'(c - 1) : 2'h0, "level");
                check(vectorAddrBus, {13'h1a5b, exp ? VF + 8'(i) : 8'h00}, "vector");
                irqReq <= 24'h0;
            end
            axi_write(addrOf(7 + i / 8), 16'h0000, 4'h3, r);
        end
    endtask

    task automatic test_priority();
        logic [1:0] r;
        // source 3 level 0, source 20 level 2, source 12 disabled
        axi_write(addrOf(7), 16'h0040, 4'h3, r);
        axi_write(addrOf(9), 16'h0300, 4'h3, r);
        irqReq <= 24'h101008;
        settle();
        check(vectorAddrBus[7:0], VF + 8'd20, "highest level wins");
        axi_write(addrOf(9), 16'h0100, 4'h3, r);
        settle();
        check(vectorAddrBus[7:0], VF + 8'd3, "tie lowest index");
        irqReq <= 24'h001000;
        settle();
        check(irqValid, 1'b0, "disabled never wins");
        irqReq <= 24'h0;
    endtask

    task automatic test_fast_and_reset();
        logic [31:0] d;
        logic [1:0]  r;
        // sources 2 and 5 at level 2, as a fast request must be
        axi_write(addrOf(7), 16'h0c30, 4'h3, r);
        axi_write(addrOf(11), {9'h000, 7'(VF + 8'd5)}, 4'h3, r);
        irqReq <= 24'h000024;
        settle();
        check(fastIrqHit, 1'b1, "fast hit");
        check(vectorAddrBus, FAST_ADDR, "fast address");
        @(posedge sys_clk);
        check(fetchAddr, FAST_ADDR, "core fetch");
        check({fetchFast, fetchLevel}, 3'h6, "core fetch kind");
        // reset in mid-run with requests still high
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        settle();
        check(irqValid, 1'b0, "cleared by reset");
        axi_read(addrOf(7), d, r);
        check(d, 32'h0, "field after reset");
        irqReq <= 24'h0;
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a hang anywhere ends the run as a failure
    always @(posedge sys_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == TIMEOUT) begin
            numErrors++;
            report_and_stop();
        end
    end

    initial begin
        {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h3f;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, irqReq} = '0;
        {numErrors, totalChecks} = '0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        test_reset_values();
        test_reserved();
        test_fields();
        test_priority();
        test_fast_and_reset();
        report_and_stop();
    end
endmodule // test_irq_priority_vector_base
